/* core/lpsr_responder.sv */
`timescale 1ns/1ps
module lpsr_responder
   import lpsr_pkg::*;
#(
   parameter int BIT_TICKS = BIT_CYCLES,
   parameter int ECHO_DELAY_TICKS = ECHO_DELAY_CYCLES,
   parameter int ECHO_GAP_TICKS = ECHO_GAP_CYCLES,
   parameter int SLEEP_TICKS = SLEEP_CYCLES,
   parameter int CMD_GAP_TICKS = CMD_GAP_CYCLES
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic RX_PIN,
   input wire logic [7:0] LOCAL_ADDRESS,
   input wire logic CHECKSUM_APPEND_ENABLE,
   input wire lpsr_char_t DATA_CHAR,
   input wire logic DATA_DONE,
   output logic DATA_READY,
   output logic [6:0] COMMAND,
   output logic COMMAND_STROBE,
   output logic TX_PIN,
   output logic TX_OE_N,
   output logic ACTIVE
);
   lpsr_state_t state;
   logic rx_meta, rx_sync;
   logic [15:0] rx_tick;
   logic [3:0] rx_bits;
   logic [9:0] rx_shift;
   logic rx_busy, rx_strobe;
   logic [7:0] rx_byte;
   logic [21:0] timer;
   logic [6:0] cmd_latched;
   logic [15:0] sum;
   logic [15:0] ck_rem;
   logic [2:0] ck_digit;
   logic tx_start, tx_busy, tx_line, tx_busy_d;
   logic [7:0] tx_data;
   logic tx_done;
   logic [3:0] digit_val;
   logic [15:0] digit_weight;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= RX_PIN;
         rx_sync <= rx_meta;
      end
   end
   // Receiver: sample mid-bit, 10 bits after start
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_busy <= 1'b0;
         rx_tick <= 16'h0000;
         rx_bits <= 4'h0;
         rx_shift <= 10'h000;
         rx_strobe <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         rx_strobe <= 1'b0;
         if (!rx_busy) begin
            if (!rx_sync) begin
               rx_busy <= 1'b1;
               rx_tick <= 16'(BIT_TICKS + BIT_TICKS / 2 - 1);
               rx_bits <= 4'hA;
            end
         end else if (rx_tick != 16'h0000) begin
            rx_tick <= rx_tick - 16'h0001;
         end else if (rx_bits != 4'h0) begin
            rx_shift <= {rx_sync, rx_shift[9:1]};
            rx_bits <= rx_bits - 4'h1;
            // Finish at mid-stop so a back-to-back start bit is caught on time
            rx_tick <= (rx_bits == 4'h1) ? 16'h0000 : 16'(BIT_TICKS - 1);
         end else begin
            rx_busy <= 1'b0;
            // Even parity over data plus parity bit, stop must be high
            if (rx_shift[9] && !(^rx_shift[8:0])) begin
               rx_strobe <= 1'b1;
               rx_byte <= rx_shift[7:0];
            end
         end
      end
   end
   assign tx_done = tx_busy_d && !tx_busy;
   always_comb begin
      digit_weight = 16'h0001;
      case (ck_digit)
         3'h5: digit_weight = 16'h2710;
         3'h4: digit_weight = 16'h03E8;
         3'h3: digit_weight = 16'h0064;
         3'h2: digit_weight = 16'h000A;
         default: digit_weight = 16'h0001;
      endcase
      digit_val = 4'h0;
      for (int i = 1; i < 10; i++) begin
         // Widened so that nine times the top weight cannot wrap
         if ({4'h0, ck_rem} >= 20'(i) * {4'h0, digit_weight}) begin
            digit_val = 4'(i);
         end
      end
   end
   // Sequencer
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= LPSR_SLEEP;
         timer <= 22'h000000;
         cmd_latched <= 7'h00;
         sum <= SUM_RESET;
         ck_rem <= 16'h0000;
         ck_digit <= 3'h0;
         tx_start <= 1'b0;
         tx_data <= 8'h00;
         tx_busy_d <= 1'b0;
         DATA_READY <= 1'b0;
         COMMAND_STROBE <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         tx_busy_d <= tx_busy | tx_start;
         COMMAND_STROBE <= 1'b0;
         DATA_READY <= 1'b0;
         if (timer != 22'h000000) begin
            timer <= timer - 22'h000001;
         end
         case (state)
            LPSR_SLEEP: begin
               if (rx_strobe && rx_byte == LOCAL_ADDRESS && rx_byte >= ADDR_MIN
                   && rx_byte <= ADDR_MAX) begin
                  state <= LPSR_WAIT_CMD;
                  timer <= 22'(ECHO_DELAY_TICKS);
               end
            end
            LPSR_WAIT_CMD: begin
               if (rx_strobe && !rx_byte[7]) begin
                  cmd_latched <= rx_byte[6:0];
                  state <= LPSR_ECHO_WAIT;
               end else if (rx_strobe ||
                            22'(ECHO_DELAY_TICKS) - timer > 22'(CMD_GAP_TICKS + 2 * 11 * BIT_TICKS)) begin
                  // Stale or mis-ordered interrogation: echo old command
                  state <= LPSR_ECHO_WAIT;
               end
            end
            LPSR_ECHO_WAIT: begin
               if (timer == 22'h000000) begin
                  tx_start <= 1'b1;
                  tx_data <= LOCAL_ADDRESS;
                  state <= LPSR_ECHO_ADDR;
               end
            end
            LPSR_ECHO_ADDR: begin
               if (tx_done) begin
                  timer <= 22'(ECHO_GAP_TICKS);
                  state <= LPSR_ECHO_GAP;
               end
            end
            LPSR_ECHO_GAP: begin
               if (timer == 22'h000000) begin
                  tx_start <= 1'b1;
                  tx_data <= {1'b0, cmd_latched};
                  state <= LPSR_ECHO_CMD;
               end
            end
            LPSR_ECHO_CMD: begin
               if (tx_done) begin
                  COMMAND_STROBE <= 1'b1;
                  DATA_READY <= 1'b1;
                  sum <= SUM_RESET;
                  ck_digit <= 3'h0;
                  state <= LPSR_DATA;
               end
            end
            LPSR_DATA: begin
               if (ck_digit != 3'h0) begin
                  if (tx_done || !tx_busy_d) begin
                     if (!tx_busy_d && !tx_busy && !tx_start) begin
                        tx_start <= 1'b1;
                        tx_data <= ASCII_ZERO + {4'h0, digit_val};
                        // Last digit leaves the end-of-frame marker behind
                        ck_rem <= (ck_digit == 3'h1) ? 16'hFFFF
                                  : ck_rem - 16'(digit_val) * digit_weight;
                        ck_digit <= ck_digit - 3'h1;
                     end
                  end
               end else if (tx_start || tx_busy || tx_busy_d) begin
                  DATA_READY <= 1'b0;
               end else if (ck_rem == 16'hFFFF) begin
                  state <= LPSR_RECOVER;
               end else if (DATA_CHAR.valid && DATA_READY) begin
                  tx_start <= 1'b1;
                  tx_data <= {1'b0, DATA_CHAR.data};
                  sum <= sum + {9'h000, DATA_CHAR.data};
                  if (DATA_CHAR.last) begin
                     if (CHECKSUM_APPEND_ENABLE) begin
                        ck_rem <= 16'h0000 - (sum + {9'h000, DATA_CHAR.data});
                        ck_digit <= 3'h5;
                     end else begin
                        ck_rem <= 16'hFFFF;
                     end
                  end
               end else if (DATA_DONE) begin
                  state <= LPSR_RECOVER;
                  timer <= 22'(SLEEP_TICKS);
               end else if (!DATA_READY) begin
                  // Ready stays a one-cycle pulse while the engine has nothing
                  DATA_READY <= 1'b1;
               end
            end
            LPSR_RECOVER: begin
               if (timer == 22'h000000 && ck_rem != 16'hFFFF) begin
                  state <= LPSR_SLEEP;
               end else if (ck_rem == 16'hFFFF) begin
                  ck_rem <= 16'h0000;
                  timer <= 22'(SLEEP_TICKS);
               end
            end
            default: state <= LPSR_SLEEP;
         endcase
      end
   end
   lpsr_uart_tx #(
      .BIT_TICKS(BIT_TICKS)
   ) u_tx (
      .clk(CLK),
      .resetn(RESETN),
      .start(tx_start),
      .data(tx_data),
      .busy(tx_busy),
      .line(tx_line)
   );
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         TX_PIN <= 1'b1;
         TX_OE_N <= 1'b1;
         COMMAND <= 7'h00;
         ACTIVE <= 1'b0;
      end else begin
         TX_PIN <= tx_line;
         TX_OE_N <= !(tx_busy | tx_start);
         COMMAND <= cmd_latched;
         ACTIVE <= (state != LPSR_SLEEP);
      end
   end
endmodule : lpsr_responder

/* core/lpsr_pkg.sv */
package lpsr_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int BAUD = 4800;
   localparam int BIT_CYCLES = CLK_HZ / BAUD;
   localparam int CHAR_BITS = 11;
   localparam int CHAR_TIME_US = 2300;
   localparam int ECHO_DELAY_US = 22000;
   localparam int ECHO_DELAY_CYCLES = ECHO_DELAY_US * (CLK_HZ / 1000000);
   localparam int ECHO_GAP_US = 100;
   localparam int ECHO_GAP_CYCLES = ECHO_GAP_US * (CLK_HZ / 1000000);
   localparam int SLEEP_US = 50000;
   localparam int SLEEP_CYCLES = SLEEP_US * (CLK_HZ / 1000000);
   localparam int CMD_GAP_US = 5000;
   localparam int CMD_GAP_CYCLES = CMD_GAP_US * (CLK_HZ / 1000000);
   localparam logic [7:0] ADDR_MIN = 8'hC0;
   localparam logic [7:0] ADDR_MAX = 8'hFD;
   localparam logic [7:0] CHAR_STX = 8'h02;
   localparam logic [7:0] CHAR_ETX = 8'h03;
   localparam logic [7:0] CHAR_SEP = 8'h3A;
   localparam logic [7:0] CHAR_ERR = 8'h45;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [15:0] SUM_RESET = 16'h0000;
   typedef struct packed {
      logic valid;
      logic [6:0] data;
      logic last;
   } lpsr_char_t;
   typedef enum logic [2:0] {
      LPSR_SLEEP = 3'b000,
      LPSR_WAIT_CMD = 3'b001,
      LPSR_ECHO_WAIT = 3'b011,
      LPSR_ECHO_ADDR = 3'b010,
      LPSR_ECHO_GAP = 3'b110,
      LPSR_ECHO_CMD = 3'b111,
      LPSR_DATA = 3'b101,
      LPSR_RECOVER = 3'b100
   } lpsr_state_t;
endpackage : lpsr_pkg

/* core/lpsr_uart_tx.sv */
`timescale 1ns/1ps
module lpsr_uart_tx
   import lpsr_pkg::*;
#(
   parameter int BIT_TICKS = BIT_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [7:0] data,
   output logic busy,
   output logic line
);
   logic [10:0] shreg;
   logic [3:0] bits;
   logic [15:0] tick;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shreg <= 11'h7FF;
         bits <= 4'h0;
         tick <= 16'h0000;
         busy <= 1'b0;
         line <= 1'b1;
      end else if (!busy) begin
         line <= 1'b1;
         if (start) begin
            // Start, 8 data, even parity, stop
            shreg <= {1'b1, ^data, data, 1'b0};
            bits <= 4'(CHAR_BITS);
            tick <= 16'h0000;
            busy <= 1'b1;
         end
      end else if (tick == 16'h0000) begin
         if (bits == 4'h0) begin
            busy <= 1'b0;
            line <= 1'b1;
         end else begin
            line <= shreg[0];
            shreg <= {1'b1, shreg[10:1]};
            bits <= bits - 4'h1;
            tick <= 16'(BIT_TICKS - 1);
         end
      end else begin
         tick <= tick - 16'h0001;
      end
   end
endmodule : lpsr_uart_tx

/* sim/lpsr_responder_properties.sv */
`timescale 1ns/1ps
module lpsr_responder_properties
   import lpsr_pkg::*;
#(
   parameter int SLEEP_TICKS = SLEEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic DATA_READY,
   input wire logic [6:0] COMMAND,
   input wire logic COMMAND_STROBE,
   input wire logic TX_PIN,
   input wire logic TX_OE_N,
   input wire logic ACTIVE
);
   localparam int ECHO_LO = 360;
   localparam int ECHO_HI = 440;
   int idle;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // Cycles since the driver was last on
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         idle <= 0;
      end else begin
         idle <= TX_OE_N ? idle + 1 : 0;
      end
   end
   a_sleep_no_drive: assert property (!ACTIVE |-> TX_OE_N)
      else $error("driver on while asleep");
   a_idle_line_high: assert property (TX_OE_N |-> TX_PIN)
      else $error("released line not high");
   a_strobe_one_cycle: assert property (COMMAND_STROBE |=> !COMMAND_STROBE)
      else $error("strobe too long");
   a_ready_one_cycle: assert property (DATA_READY |=> !DATA_READY)
      else $error("ready too long");
   a_ready_when_active: assert property (DATA_READY || COMMAND_STROBE |-> ACTIVE)
      else $error("handshake while asleep");
   a_echo_start_window: assert property ($rose(ACTIVE) |-> ##[ECHO_LO:ECHO_HI] !TX_OE_N)
      else $error("echo not started in window");
   a_no_early_echo: assert property ($rose(ACTIVE) |-> TX_OE_N [*8])
      else $error("echo too early");
   a_sleep_recovery: assert property ($fell(ACTIVE) |-> idle >= SLEEP_TICKS - 2)
      else $error("sleep before recovery");
   a_command_when_active: assert property ($changed(COMMAND) |-> ACTIVE)
      else $error("command changed while asleep");
   cover property ($rose(ACTIVE));
   cover property (COMMAND_STROBE);
   cover property ($fell(ACTIVE));
endmodule : lpsr_responder_properties
bind lpsr_responder lpsr_responder_properties #(.SLEEP_TICKS(SLEEP_TICKS)) u_props (
   .CLK(CLK), .RESETN(RESETN), .DATA_READY(DATA_READY), .COMMAND(COMMAND),
   .COMMAND_STROBE(COMMAND_STROBE), .TX_PIN(TX_PIN), .TX_OE_N(TX_OE_N), .ACTIVE(ACTIVE));

/* sim/lpsr_host_model.sv */
`timescale 1ns/1ps
module lpsr_host_model
   import lpsr_pkg::*;
#(
   parameter int BIT_TICKS = 8
) (
   input wire logic CLK,
   input wire logic dev_line,
   output logic host_tx,
   output logic host_oe
);
   logic [7:0] rx_q[$];
   logic [9:0] r;
   logic rx_err;
   initial begin
      host_tx = 1'b1;
      host_oe = 1'b0;
      rx_err = 1'b0;
   end
   // Flip forces a parity error on purpose
   task automatic send_byte(input logic [7:0] b, input logic flip);
      logic [10:0] f;
      f = {1'b1, ^b ^ flip, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         host_tx <= f[i];
         repeat (BIT_TICKS) @(posedge CLK);
      end
   endtask : send_byte
   task automatic poll(input logic [7:0] a, input logic [7:0] c, input logic flip);
      @(posedge CLK);
      host_oe <= 1'b1;
      repeat (4) @(posedge CLK);
      send_byte(a, flip);
      send_byte(c, 1'b0);
      repeat (2) @(posedge CLK);
      host_oe <= 1'b0;
   endtask : poll
   // Listening only while released keeps own bytes out
   always begin
      @(negedge dev_line iff !host_oe);
      repeat (BIT_TICKS / 2) @(posedge CLK);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT_TICKS) @(posedge CLK);
         r[i] = dev_line;
      end
      if (r[9] !== 1'b1 || (^r[8:0]) !== 1'b0) rx_err = 1'b1;
      rx_q.push_back(r[7:0]);
   end
endmodule : lpsr_host_model

/* sim/tb_level_probe_serial_responder.sv */
`timescale 1ns/1ps
module tb_level_probe_serial_responder;
   import lpsr_pkg::*;
   logic CLK, RESETN, CHECKSUM_APPEND_ENABLE, DATA_DONE, DATA_READY;
   logic COMMAND_STROBE, TX_PIN, TX_OE_N, ACTIVE, host_tx, host_oe, bus, rx_line;
   logic [7:0] LOCAL_ADDRESS;
   logic [6:0] COMMAND;
   lpsr_char_t DATA_CHAR;
   int n_mismatch, check_count;
   localparam int TB_BIT_TICKS = 8;
   localparam int TB_ECHO_TICKS = 400;
   localparam int TB_GAP_TICKS = 4;
   localparam int TB_SLEEP_TICKS = 200;
   localparam int TB_CMD_TICKS = 100;
   // Released bus is biased high
   assign bus = host_oe ? host_tx : (!TX_OE_N ? TX_PIN : 1'b1);
   assign rx_line = host_oe ? host_tx : 1'b1;
   lpsr_responder #(.BIT_TICKS(TB_BIT_TICKS), .ECHO_DELAY_TICKS(TB_ECHO_TICKS),
      .ECHO_GAP_TICKS(TB_GAP_TICKS), .SLEEP_TICKS(TB_SLEEP_TICKS),
      .CMD_GAP_TICKS(TB_CMD_TICKS)) dut (
      .CLK(CLK), .RESETN(RESETN), .RX_PIN(rx_line), .LOCAL_ADDRESS(LOCAL_ADDRESS),
      .CHECKSUM_APPEND_ENABLE(CHECKSUM_APPEND_ENABLE), .DATA_CHAR(DATA_CHAR),
      .DATA_DONE(DATA_DONE), .DATA_READY(DATA_READY), .COMMAND(COMMAND),
      .COMMAND_STROBE(COMMAND_STROBE), .TX_PIN(TX_PIN), .TX_OE_N(TX_OE_N), .ACTIVE(ACTIVE));
   lpsr_host_model #(.BIT_TICKS(TB_BIT_TICKS)) host (.CLK(CLK), .dev_line(bus),
      .host_tx(host_tx),
      .host_oe(host_oe));
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic s_silent(input logic [7:0] a, input logic flip);
      host.rx_q.delete();
      host.poll(a, 8'h0A, flip);
      repeat (600) @(posedge CLK);
      check("silent rx", host.rx_q.size(), 0);
      check("asleep", ACTIVE, 1'b0);
   endtask : s_silent
   task automatic s_frame(input logic [7:0] a, input logic [6:0] c, input logic en);
      logic [7:0] fr [0:4];
      logic [15:0] sum;
      int n;
      int p;
      fr = '{8'h02, 8'h31, 8'h3A, 8'h45, 8'h03};
      sum = 16'h0000;
      LOCAL_ADDRESS <= a;
      CHECKSUM_APPEND_ENABLE <= en;
      host.rx_q.delete();
      host.poll(a, {1'b0, c}, 1'b0);
      for (n = 0; n < 3000 && COMMAND_STROBE !== 1'b1; n++) @(posedge CLK);
      check("command", COMMAND, c);
      check("echo addr", host.rx_q[0], a);
      check("echo cmd", host.rx_q[1], c);
      for (int i = 0; i < 5; i++) begin
         DATA_CHAR <= '{valid: 1'b1, data: fr[i][6:0], last: i == 4};
         sum += fr[i];
         @(posedge CLK);
         for (n = 0; n < 3000 && DATA_READY !== 1'b1; n++) @(posedge CLK);
      end
      DATA_CHAR <= '0;
      sum = -sum;
      for (n = 0; n < 3000 && host.rx_q.size() < (en ? 12 : 7); n++) @(posedge CLK);
      check("frame length", host.rx_q.size(), en ? 12 : 7);
      for (int i = 0; i < 5; i++) check("frame", host.rx_q[i + 2], fr[i]);
      p = 10000;
      for (int i = 0; i < 5 && en; i++) begin
         check("digit", host.rx_q[i + 7], 16'h30 + (sum / p) % 10);
         p = p / 10;
      end
      check("parity", host.rx_err, 1'b0);
      for (n = 0; n < 1000 && ACTIVE !== 1'b0; n++) @(posedge CLK);
      check("driver off", TX_OE_N, 1'b1);
      check("asleep after frame", ACTIVE, 1'b0);
      repeat (20) @(posedge CLK);
   endtask : s_frame
   task automatic s_empty(input logic [7:0] a, input logic [6:0] c);
      int n;
      LOCAL_ADDRESS <= a;
      host.rx_q.delete();
      host.poll(a, {1'b0, c}, 1'b0);
      for (n = 0; n < 3000 && COMMAND_STROBE !== 1'b1; n++) @(posedge CLK);
      check("empty command", COMMAND, c);
      DATA_DONE <= 1'b1;
      @(posedge CLK);
      DATA_DONE <= 1'b0;
      repeat (150) @(posedge CLK);
      check("recovering", ACTIVE, 1'b1);
      check("empty rx", host.rx_q.size(), 2);
      for (n = 0; n < 300 && ACTIVE !== 1'b0; n++) @(posedge CLK);
      check("empty asleep", ACTIVE, 1'b0);
      check("empty driver off", TX_OE_N, 1'b1);
      repeat (20) @(posedge CLK);
   endtask : s_empty
   initial begin
      RESETN = 1'b0;
      LOCAL_ADDRESS = 8'hC0;
      CHECKSUM_APPEND_ENABLE = 1'b1;
      DATA_CHAR = '0;
      DATA_DONE = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (16) @(posedge CLK);
      check("reset oe", TX_OE_N, 1'b1);
      check("reset pin", TX_PIN, 1'b1);
      RESETN <= 1'b1;
      @(posedge CLK);
      s_silent(8'hC6, 1'b0);
      s_silent(8'hC0, 1'b1);
      s_frame(8'hC0, 7'h0A, 1'b1);
      s_frame(8'hFD, 7'h7F, 1'b0);
      s_empty(8'hC3, 7'h19);
      report_and_stop();
   end
   initial begin
      #(50 * 20000);
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb_level_probe_serial_responder
